// ==== design/keypad_pkg.sv ====
package keypad_pkg;

    // ==========================================================
    // Keypad geometry
    localparam int ROWS = 4;
    localparam int MAX_COLS = 4;

    // ==========================================================
    // Key codes
    localparam logic [4:0] CODE_STAR = 5'h0a;
    localparam logic [4:0] CODE_HASH = 5'h0b;
    localparam logic [4:0] CODE_LETTER_A = 5'h14;
    localparam logic [4:0] CODE_RESET = 5'h00;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int ROW_SETTLE_US = 10;
    localparam int ROW_SETTLE_CYCLES = ROW_SETTLE_US * CLK_MHZ;
    localparam int DEBOUNCE_MS = 20;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Pin group carried as one bundle
    typedef struct packed {
        logic [ROWS-1:0] row_out;
        logic [ROWS-1:0] row_oe;
        logic [MAX_COLS-1:0] col_pull_en;
    } keypad_pins_t;

endpackage

// ==== design/key_decode.sv ====
`timescale 1ns/1ps
`default_nettype none

// Maps a row and column position to the key code; the result is registered
module key_decode (
    input wire logic core_clk,
    input wire logic rst_sync_n,
    input wire logic [1:0] row,
    input wire logic [1:0] col,
    output logic [4:0] code
);
    import keypad_pkg::*;

    logic [4:0] next_code;

    // ==========================================================
    // Position to code
    always_comb begin
        next_code = CODE_RESET;
        if (col == 2'd3) begin
            next_code = 5'(CODE_LETTER_A + 5'(row));
        end else if (row == 2'd3) begin
            case (col)
                2'd0: next_code = CODE_STAR;
                2'd1: next_code = 5'h00;
                2'd2: next_code = CODE_HASH;
                default: next_code = CODE_RESET;
            endcase
        end else begin
            next_code = 5'({row, 2'b00} - {2'b00, row} + {2'b00, col} + 4'h1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            code <= CODE_RESET;
        end else begin
            code <= next_code;
        end
    end

endmodule // key_decode

`default_nettype wire

// ==== design/keypad_scanner.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Four row lines are scanned against three columns, or four when the fourth is enabled.
// - A digit key reports its own value as the key code.
// - The star key reports ten and the hash key reports eleven.
// - Scanning runs while enabled and holds on a pressed row until release; the stored code updates on every accepted press.
// - Each newly accepted press raises a one-cycle event to the host.
// - Enabling the scanner configures row outputs and column pull-ups by itself.
// - Disabling stops scanning and releases every keypad pin to the unconfigured state.
module keypad_scanner #(
    parameter int SETTLE_CYCLES = keypad_pkg::ROW_SETTLE_CYCLES,
    parameter int DEBOUNCE = keypad_pkg::DEBOUNCE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic four_columns,
    input wire logic [keypad_pkg::MAX_COLS-1:0] column_line_in,
    output keypad_pkg::keypad_pins_t pins,
    output logic [4:0] key_code,
    output logic key_event,
    output logic active
);
    import keypad_pkg::*;

    typedef enum {IDLE, SETTLE, SAMPLE, STABLE, WAIT_RELEASE} scan_state_t;

    localparam int CNT_W = $clog2(DEBOUNCE + SETTLE_CYCLES + 1);

    // ==========================================================
    // Reset release
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ==========================================================
    // Scan state
    scan_state_t state, next_state;
    logic [1:0] row, next_row;
    logic [1:0] hit_col, next_hit_col;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic event_q, next_event;
    logic load_code, next_load;
    logic [MAX_COLS-1:0] col_mask;
    logic [MAX_COLS-1:0] pressed;
    logic any_press;
    logic [1:0] first_col;
    logic [4:0] decoded;

    // Fourth column only counts on a 4x4 pad
    assign col_mask = four_columns ? 4'hf : 4'h7;
    assign pressed = ~column_line_in & col_mask;

    // Lowest pressed column wins if two keys share a row
    always_comb begin
        first_col = 2'd0;
        any_press = |pressed;
        for (int i = MAX_COLS - 1; i >= 0; i--) begin
            if (pressed[i]) begin
                first_col = 2'(i);
            end
        end
    end

    always_comb begin
        next_state = state;
        next_row = row;
        next_hit_col = hit_col;
        next_cnt = cnt;
        next_event = 1'b0;
        next_load = 1'b0;
        case (state)
            IDLE: begin
                next_row = 2'd0;
                next_cnt = '0;
                if (enable) begin
                    next_state = SETTLE;
                end
            end
            SETTLE: begin
                // Row line and pull-ups need time before the columns are trusted
                if (cnt >= CNT_W'(SETTLE_CYCLES - 1)) begin
                    next_cnt = '0;
                    next_state = SAMPLE;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            SAMPLE: begin
                if (any_press) begin
                    next_hit_col = first_col;
                    next_cnt = '0;
                    next_state = STABLE;
                end else begin
                    next_row = row + 2'd1;
                    next_cnt = '0;
                    next_state = SETTLE;
                end
            end
            STABLE: begin
                // Any bounce sends the same row back through settling rather than restarting the timer alone
                if (!pressed[hit_col]) begin
                    next_cnt = '0;
                    next_state = SETTLE;
                end else if (cnt >= CNT_W'(DEBOUNCE - 1)) begin
                    next_load = 1'b1;
                    next_state = WAIT_RELEASE;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            WAIT_RELEASE: begin
                if (load_code) begin
                    next_event = 1'b1;
                end
                if (!pressed[hit_col]) begin
                    next_cnt = '0;
                    next_state = SETTLE;
                end
            end
            default: next_state = IDLE;
        endcase
        // Shutdown drops a press that was not yet accepted, so no code loads silently
        if (!enable) begin
            next_state = IDLE;
            next_load = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= IDLE;
            row <= 2'd0;
            hit_col <= 2'd0;
            cnt <= '0;
            event_q <= 1'b0;
            load_code <= 1'b0;
        end else begin
            state <= next_state;
            row <= next_row;
            hit_col <= next_hit_col;
            cnt <= next_cnt;
            event_q <= next_event;
            load_code <= next_load;
        end
    end

    // ==========================================================
    // Code lookup
    key_decode u_key_decode (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .row(row),
        .col(hit_col),
        .code(decoded)
    );

    // ==========================================================
    // Stored code, held until the next accepted press
    logic [4:0] next_key_code;

    always_comb begin
        next_key_code = key_code;
        if (load_code) begin
            next_key_code = decoded;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            key_code <= CODE_RESET;
        end else begin
            key_code <= next_key_code;
        end
    end

    // ==========================================================
    // Pin drive: active row low, others released; all off when idle
    keypad_pins_t next_pins;

    always_comb begin
        next_pins = '0;
        if (next_state != IDLE) begin
            next_pins.row_oe[next_row] = 1'b1;
            next_pins.col_pull_en = col_mask;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    assign key_event = event_q;
    assign active = (state != IDLE);

    // ==========================================================
    // Checks
    sequence held_press_s;
        state == STABLE && cnt == CNT_W'(DEBOUNCE - 1) && pressed[hit_col] && enable;
    endsequence

    press_to_event_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        held_press_s |-> ##2 key_event)
        else $error("accepted press gave no event");

    code_updates_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        load_code |=> key_code == $past(decoded))
        else $error("key code not loaded");

    code_stable_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !load_code |=> $stable(key_code))
        else $error("key code changed without press");

    event_one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        key_event |=> !key_event)
        else $error("event longer than one cycle");

    shutdown_pins_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !enable |=> pins == '0 && !active)
        else $error("pins not released on shutdown");

    one_row_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        $onehot0(pins.row_oe) && pins.row_out == '0)
        else $error("more than one row driven");

    start_config_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !active && enable |=> pins.row_oe == 4'h1 && pins.col_pull_en != '0)
        else $error("pins not configured on start");

    three_col_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !four_columns && state == STABLE |-> hit_col != 2'd3)
        else $error("fourth column used on 4x3 pad");

    debounce_min_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        $rose(state == STABLE) |-> !load_code [*2])
        else $error("press accepted before debounce");

endmodule // keypad_scanner

`default_nettype wire

// ==== verification/keypad_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Passive switch matrix: one key contact at a time
module keypad_model (
    input wire logic core_clk,
    input wire keypad_pkg::keypad_pins_t pins,
    input wire logic press,
    input wire logic [1:0] press_row,
    input wire logic [1:0] press_col,
    output logic [3:0] column_line_in
);
    import keypad_pkg::*;
    logic toggle;

    // Unpulled columns float, so they wander instead of holding a level
    initial toggle = 1'b0;
    always @(posedge core_clk) toggle <= ~toggle;

    // A closed contact pulls its column low only while its row drives low
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            if (!pins.col_pull_en[c]) begin
                column_line_in[c] = toggle ^ c[0];
            end else if (press && c == press_col && pins.row_oe[press_row]
                         && !pins.row_out[press_row]) begin
                column_line_in[c] = 1'b0;
            end else begin
                column_line_in[c] = 1'b1;
            end
        end
    end
endmodule // keypad_model

`default_nettype wire

// ==== verification/matrix_keypad_scanner_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the keypad scanner
module matrix_keypad_scanner_bench;
    import keypad_pkg::*;
    logic core_clk, rst_n, enable, four_columns, press, key_event, active;
    logic [1:0] press_row, press_col;
    logic [3:0] column_line_in;
    logic [4:0] key_code;
    keypad_pins_t pins;
    int fail_count, total_checks, cycles;

    // Short counts keep the run brief
    keypad_scanner #(.SETTLE_CYCLES(2), .DEBOUNCE(4)) u_keypad_scanner (
        .core_clk(core_clk), .rst_n(rst_n), .enable(enable),
        .four_columns(four_columns), .column_line_in(column_line_in),
        .pins(pins), .key_code(key_code), .key_event(key_event), .active(active)
    );
    keypad_model u_keypad_model (
        .core_clk(core_clk), .pins(pins), .press(press), .press_row(press_row),
        .press_col(press_col), .column_line_in(column_line_in)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Cut a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Count events over a span and keep the code seen with the last one
    task automatic watch(input int span, output int n, output logic [4:0] code);
        n = 0;
        code = 5'h1f;
        repeat (span) begin
            @(negedge core_clk);
            if (key_event === 1'b1) begin
                n++;
                code = key_code;
            end
        end
    endtask

    function automatic logic [4:0] exp_code(input int r, input int c);
        if (c == 3) return CODE_LETTER_A + 5'(r);
        if (r < 3) return 5'(r * 3 + c + 1);
        return (c == 0) ? CODE_STAR : (c == 1) ? 5'h00 : CODE_HASH;
    endfunction

    // Hold a key well past one event, then release it
    task automatic hit(input int r, input int c, input int exp_n);
        int n;
        logic [4:0] code;
        press_row = 2'(r);
        press_col = 2'(c);
        press = 1'b1;
        watch(150, n, code);
        check(8'(n), 8'(exp_n));
        if (exp_n == 1) check(8'(code), 8'(exp_code(r, c)));
        press = 1'b0;
        watch(60, n, code);
        check(8'(n), 8'h00);
    endtask

    task automatic t_idle_then_enable();
        check(8'(pins), 8'h00);
        check(8'(active), 8'h00);
        enable = 1'b1;
        four_columns = 1'b1;
        repeat (3) @(negedge core_clk);
        check(8'(pins.col_pull_en), 8'h0f);
        check(8'($countones(pins.row_oe)), 8'h01);
        check(8'(pins.row_out & pins.row_oe), 8'h00);
        check(8'(active), 8'h01);
    endtask

    task automatic t_all_keys();
        for (int k = 0; k < 16; k++) hit(k / 4, k % 4, 1);
        hit(2, 2, 1);
    endtask

    task automatic t_three_columns();
        four_columns = 1'b0;
        repeat (3) @(negedge core_clk);
        check(8'(pins.col_pull_en), 8'h07);
        hit(0, 3, 0);
        hit(3, 0, 1);
    endtask

    // Contact chatters 3 on, 2 off: never stable long enough, so the debounce restarts
    task automatic t_bounce();
        int n;
        logic [4:0] code;
        press_row = 2'd2;
        press_col = 2'd0;
        repeat (12) begin
            press = 1'b1;
            watch(3, n, code);
            check(8'(n), 8'h00);
            press = 1'b0;
            watch(2, n, code);
            check(8'(n), 8'h00);
        end
        check(8'(key_code), 8'(CODE_STAR));
        hit(2, 0, 1);
    endtask

    task automatic t_shutdown();
        int n;
        logic [4:0] code;
        press_row = 2'd1;
        press_col = 2'd1;
        press = 1'b1;
        repeat (6) @(negedge core_clk);
        enable = 1'b0;
        repeat (2) @(negedge core_clk);
        check(8'(pins), 8'h00);
        check(8'(active), 8'h00);
        watch(100, n, code);
        check(8'(n), 8'h00);
        press = 1'b0;
        enable = 1'b1;
        repeat (2) @(negedge core_clk);
        hit(3, 2, 1);
    endtask

    initial begin
        rst_n = 1'b0;
        enable = 1'b0;
        four_columns = 1'b1;
        press = 1'b0;
        press_row = 2'd0;
        press_col = 2'd0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_idle_then_enable();
        t_all_keys();
        t_three_columns();
        t_bounce();
        t_shutdown();
        conclude();
    end
endmodule // matrix_keypad_scanner_bench

`default_nettype wire
